// ==== verilog/sfp_core.sv ====
`timescale 1ns/1ps
// sfp_core: serial flash command sequencer with write protection
// assumes spi pins are asynchronous and the array sits behind the mem ports
`include "sfp_regs.svh"
module sfp_core
#(
  parameter int unsigned SEC_ERASE_CYC  =
    `SFP_SEC_ERASE_MS * `SFP_CLK_MHZ * 1000,
  parameter int unsigned CHIP_ERASE_CYC =
    `SFP_CHIP_ERASE_MS * `SFP_CLK_MHZ * 1000
)
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_cs_n,
  input  wire logic       i_sck,
  input  wire logic       i_si,
  input  wire logic       i_wp_n,
  output logic            o_so,
  output logic            o_so_oe_n,
  output logic [17:0]     o_mem_rd_addr,
  input  wire logic [7:0] i_mem_rd_data,
  output logic            o_mem_wr_valid,
  input  wire logic       i_mem_wr_ready,
  output logic [17:0]     o_mem_wr_addr,
  output logic [7:0]      o_mem_wr_data,
  output logic            o_mem_erase,
  output logic [3:0]      o_mem_erase_mask,
  output sfp_pkg::sfp_cyc_t o_cyc_state
);
  import sfp_pkg::*;

  logic [3:0]  s1_r;
  logic [3:0]  s2_r;
  logic [3:0]  s3_r;
  logic        cs_s;
  logic        si_s;
  logic        wp_s;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_rise;
  sfp_xfer_t   xfer_r;
  sfp_cmd_t    cmd_r;
  sfp_cmd_t    cmd_in;
  logic [2:0]  bit_r;
  logic [1:0]  nadr_r;
  logic [7:0]  sh_r;
  logic [7:0]  rx_byte;
  logic        byte_done;
  logic        got_data_r;
  logic [17:0] addr_r;
  logic [7:0]  stat_in_r;
  logic [7:0]  tx_r;
  logic        tx_act_r;
  logic        so_r;
  logic        ld1_r;
  logic        ld2_r;
  logic        ld_mem;
  logic        ld_stat;
  logic        wel_r;
  logic        ppe_r;
  logic [1:0]  bg_r;
  logic [7:0]  stat;
  logic        hw_prot;
  logic [3:0]  guard;
  logic        busy;
  sfp_cyc_t    cyc_r;
  logic [27:0] tmr_r;
  logic [8:0]  idx_r;
  logic        is_stat_r;
  logic        done;
  logic        go_stat;
  logic        go_prog;
  logic        go_sec;
  logic        go_chip;
  logic [3:0]  sec_mask;
  logic [7:0]  pg_mem [256];
  logic [255:0] pg_vld_r;
  logic        in_valid;
  logic        in_ready;
  logic        erase_r;
  logic [3:0]  emask_r;

  // pin synchronisers; stage three only feeds edge detection
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_r <= `SFP_PINS_RST;
      s2_r <= `SFP_PINS_RST;
      s3_r <= `SFP_PINS_RST;
    end
    else
    begin
      s1_r <= {i_cs_n, i_sck, i_si, i_wp_n};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign cs_s      = s2_r[3];
  assign si_s      = s2_r[1];
  assign wp_s      = s2_r[0];
  assign sck_rise  = s2_r[2] && !s3_r[2] && !cs_s;
  assign sck_fall  = !s2_r[2] && s3_r[2] && !cs_s;
  assign cs_rise   = s2_r[3] && !s3_r[3];
  assign rx_byte   = {sh_r[6:0], si_s};
  assign byte_done = sck_rise && bit_r == 3'h7;
  assign cmd_in    = sfp_decode(rx_byte);
  assign busy      = cyc_r != C_IDLE;
  assign hw_prot   = !wp_s && ppe_r;
  assign guard     = sfp_guard_mask(bg_r);
  assign sec_mask  = 4'h1 << addr_r[17:16];

  // serial framing: opcode, three address bytes, then data
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      xfer_r     <= T_OP;
      cmd_r      <= K_NONE;
      bit_r      <= 3'h0;
      nadr_r     <= 2'h0;
      sh_r       <= 8'h00;
      got_data_r <= 1'b0;
      addr_r     <= 18'h00000;
      stat_in_r  <= 8'h00;
    end
    else if (cs_s)
    begin
      xfer_r     <= T_OP;
      bit_r      <= 3'h0;
      nadr_r     <= 2'h0;
      got_data_r <= 1'b0;
    end
    else if (sck_rise)
    begin
      sh_r  <= rx_byte;
      bit_r <= bit_r + 3'h1;
      if (bit_r == 3'h7)
      begin
        unique case (xfer_r)
          T_OP:
          begin
            // only status reads get through a running cycle
            if (busy && cmd_in != K_STAT_RD)
            begin
              cmd_r  <= K_NONE;
              xfer_r <= T_SKIP;
            end
            else
            begin
              cmd_r <= cmd_in;
              unique case (cmd_in)
                K_READ, K_PROG, K_SEC: xfer_r <= T_ADDR;
                K_STAT_WR, K_STAT_RD:  xfer_r <= T_DATA;
                default:               xfer_r <= T_SKIP;
              endcase
            end
          end
          T_ADDR:
          begin
            addr_r <= {addr_r[9:0], rx_byte};
            nadr_r <= nadr_r + 2'h1;
            if (nadr_r == 2'h2)
            begin
              xfer_r <= T_DATA;
            end
          end
          T_DATA:
          begin
            got_data_r <= 1'b1;
            if (cmd_r == K_STAT_WR)
            begin
              stat_in_r <= rx_byte;
            end
            else if (cmd_r == K_READ)
            begin
              addr_r <= addr_r + 18'h1;
            end
            else if (cmd_r == K_PROG)
            begin
              addr_r[7:0] <= addr_r[7:0] + 8'h1;
            end
          end
          T_SKIP:
          begin
            xfer_r <= T_SKIP;
          end
        endcase
      end
    end
  end

  // read data fetch: address settles, then the array answers a cycle later
  assign ld_stat = byte_done && (cmd_r == K_STAT_RD && xfer_r == T_DATA ||
                                 xfer_r == T_OP && cmd_in == K_STAT_RD);
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ld1_r <= 1'b0;
      ld2_r <= 1'b0;
    end
    else
    begin
      ld1_r <= byte_done && cmd_r == K_READ &&
               (xfer_r == T_DATA || xfer_r == T_ADDR && nadr_r == 2'h2);
      ld2_r <= ld1_r && !cs_s;
    end
  end
  assign ld_mem        = ld2_r && !cs_s;
  assign o_mem_rd_addr = addr_r;

  always_comb
  begin
    stat                  = 8'h00;
    stat[`SFP_ST_PPE]     = ppe_r;
    stat[`SFP_ST_BGH]     = bg_r[1];
    stat[`SFP_ST_BGL]     = bg_r[0];
    stat[`SFP_ST_WEL]     = wel_r;
    if (busy)
    begin
      stat = `SFP_ST_BUSY_VAL;
    end
  end

  // output shifter: new bit on each falling clock edge
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tx_r     <= 8'h00;
      tx_act_r <= 1'b0;
      so_r     <= 1'b0;
    end
    else if (cs_s)
    begin
      tx_act_r <= 1'b0;
    end
    else if (ld_stat)
    begin
      tx_r     <= stat;
      tx_act_r <= 1'b1;
    end
    else if (ld_mem)
    begin
      tx_r     <= i_mem_rd_data;
      tx_act_r <= 1'b1;
    end
    else if (sck_fall && tx_act_r)
    begin
      so_r <= tx_r[7];
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end
  assign o_so      = so_r;
  assign o_so_oe_n = !(tx_act_r && !cs_s);

  // commands act at select release, on a whole byte only
  assign go_stat = cs_rise && bit_r == 3'h0 && cmd_r == K_STAT_WR &&
                   got_data_r && wel_r && !hw_prot;
  assign go_prog = cs_rise && bit_r == 3'h0 && cmd_r == K_PROG &&
                   got_data_r && wel_r &&
                   (guard & sec_mask) == 4'h0;
  assign go_sec  = cs_rise && bit_r == 3'h0 && cmd_r == K_SEC &&
                   xfer_r == T_DATA && wel_r &&
                   (guard & sec_mask) == 4'h0;
  assign go_chip = cs_rise && bit_r == 3'h0 && cmd_r == K_CHIP &&
                   wel_r && guard != 4'hf;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wel_r <= 1'b0;
    end
    else if (done)
    begin
      wel_r <= 1'b0;
    end
    else if (cs_rise && bit_r == 3'h0 && cmd_r == K_UNLOCK)
    begin
      wel_r <= 1'b1;
    end
    else if (cs_rise && bit_r == 3'h0 && cmd_r == K_LOCK)
    begin
      wel_r <= 1'b0;
    end
  end

  // new protection bits land when the status cycle ends
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ppe_r <= `SFP_PPE_RST;
      bg_r  <= `SFP_BG_RST;
    end
    else if (done && is_stat_r)
    begin
      ppe_r <= stat_in_r[`SFP_ST_PPE];
      bg_r  <= {stat_in_r[`SFP_ST_BGH], stat_in_r[`SFP_ST_BGL]};
    end
  end

  // page buffer: bytes wrap inside the page, later ones overwrite
  always_ff @(posedge i_ref_clk)
  begin
    if (byte_done && xfer_r == T_DATA && cmd_r == K_PROG)
    begin
      pg_mem[addr_r[7:0]] <= rx_byte;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pg_vld_r <= '0;
    end
    else if (byte_done && xfer_r == T_OP && cmd_in == K_PROG && !busy)
    begin
      pg_vld_r <= '0;
    end
    else if (byte_done && xfer_r == T_DATA && cmd_r == K_PROG)
    begin
      pg_vld_r[addr_r[7:0]] <= 1'b1;
    end
  end

  // internal cycle: drain the page, then time out the array operation
  assign done = cyc_r == C_WAIT && tmr_r == 28'h0;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cyc_r     <= C_IDLE;
      tmr_r     <= 28'h0;
      idx_r     <= 9'h000;
      is_stat_r <= 1'b0;
      erase_r   <= 1'b0;
      emask_r   <= 4'h0;
    end
    else
    begin
      erase_r <= 1'b0;
      unique case (cyc_r)
        C_IDLE:
        begin
          is_stat_r <= go_stat;
          idx_r     <= 9'h000;
          tmr_r     <= 28'(`SFP_PROG_CYC);
          if (go_prog)
          begin
            cyc_r <= C_PROG;
          end
          else if (go_stat)
          begin
            cyc_r <= C_WAIT;
          end
          else if (go_sec)
          begin
            cyc_r   <= C_WAIT;
            erase_r <= 1'b1;
            emask_r <= sec_mask;
            tmr_r   <= 28'(SEC_ERASE_CYC);
          end
          else if (go_chip)
          begin
            cyc_r   <= C_WAIT;
            erase_r <= 1'b1;
            emask_r <= ~guard;
            tmr_r   <= 28'(CHIP_ERASE_CYC);
          end
        end
        C_PROG:
        begin
          if (!idx_r[8] && (!pg_vld_r[idx_r[7:0]] || in_ready))
          begin
            idx_r <= idx_r + 9'h001;
          end
          if (idx_r[8] && !o_mem_wr_valid)
          begin
            cyc_r <= C_WAIT;
          end
        end
        C_WAIT:
        begin
          if (tmr_r == 28'h0)
          begin
            cyc_r <= C_IDLE;
          end
          else
          begin
            tmr_r <= tmr_r - 28'h1;
          end
        end
      endcase
    end
  end
  assign o_mem_erase      = erase_r;
  assign o_mem_erase_mask = emask_r;
  assign o_cyc_state      = cyc_r;
  assign in_valid = cyc_r == C_PROG && !idx_r[8] && pg_vld_r[idx_r[7:0]];

  sfp_buf2
  #(
    .W     (26),
    .DEPTH (2)
  )
  u_wbuf
  (
    .i_clk       (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (in_valid),
    .o_in_ready  (in_ready),
    .i_in_data   ({addr_r[17:8], idx_r[7:0], pg_mem[idx_r[7:0]]}),
    .o_out_valid (o_mem_wr_valid),
    .i_out_ready (i_mem_wr_ready),
    .o_out_data  ({o_mem_wr_addr, o_mem_wr_data})
  );

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  property p_wr_refused;
    cs_rise && cmd_r == K_STAT_WR && hw_prot |=> cyc_r == C_IDLE;
  endproperty
  a_wr_refused: assert property (p_wr_refused)
    else $error("status write accepted while protected");
  property p_ppe_hold;
    cyc_r == C_IDLE && hw_prot |=> ppe_r;
  endproperty
  a_ppe_hold: assert property (p_ppe_hold)
    else $error("protected enable bit was cleared");
  property p_only_stat;
    byte_done && xfer_r == T_OP && busy |=> cmd_r inside {K_NONE, K_STAT_RD};
  endproperty
  a_only_stat: assert property (p_only_stat)
    else $error("command taken during internal cycle");
  property p_wel_clr;
    done |=> !wel_r && cyc_r == C_IDLE;
  endproperty
  a_wel_clr: assert property (p_wel_clr)
    else $error("write latch survived cycle end");
  property p_no_latch;
    cs_rise && !wel_r && cyc_r == C_IDLE |=> cyc_r == C_IDLE;
  endproperty
  a_no_latch: assert property (p_no_latch)
    else $error("write command ran without latch");
  property p_guard_wr;
    o_mem_wr_valid |-> (guard & (4'h1 << o_mem_wr_addr[17:16])) == 4'h0;
  endproperty
  a_guard_wr: assert property (p_guard_wr)
    else $error("write into guarded sector");
  property p_guard_er;
    o_mem_erase |-> (emask_r & guard) == 4'h0 && emask_r != 4'h0;
  endproperty
  a_guard_er: assert property (p_guard_er)
    else $error("erase touches guarded sector");
  property p_so_float;
    !o_so_oe_n |-> !cs_s && cmd_r inside {K_READ, K_STAT_RD};
  endproperty
  a_so_float: assert property (p_so_float)
    else $error("serial output driven while deselected");
  property p_busy_stat;
    ld_stat && busy |=> tx_r == `SFP_ST_BUSY_VAL;
  endproperty
  a_busy_stat: assert property (p_busy_stat)
    else $error("status byte not all ones while busy");
  property p_page;
    o_mem_wr_valid |-> o_mem_wr_addr[17:8] == addr_r[17:8];
  endproperty
  a_page: assert property (p_page)
    else $error("program left its page");

  c_prog: cover property (cyc_r == C_PROG ##1 cyc_r == C_WAIT);
  c_erase: cover property (o_mem_erase);
  c_read2: cover property (ld_mem ##[1:200] ld_mem);
  c_poll: cover property (ld_stat && busy);
endmodule : sfp_core

// ==== verilog/sfp_regs.svh ====
// sfp_regs.svh: opcodes, status byte layout, reset values and cycle times
// assumes a 40 MHz reference clock and an 18-bit byte address space
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH
`define SFP_OP_MASK       8'hf7
`define SFP_OP_UNLOCK     8'h06
`define SFP_OP_LOCK       8'h04
`define SFP_OP_STAT_RD    8'h05
`define SFP_OP_STAT_WR    8'h01
`define SFP_OP_READ       8'h03
`define SFP_OP_PROG       8'h02
`define SFP_OP_SEC_ERASE  8'h52
`define SFP_OP_CHIP_ERASE 8'h62
`define SFP_ST_PPE        7
`define SFP_ST_BGH        3
`define SFP_ST_BGL        2
`define SFP_ST_WEL        1
`define SFP_ST_BUSY       0
`define SFP_ST_BUSY_VAL   8'hff
`define SFP_PPE_RST       1'b0
`define SFP_BG_RST        2'h0
`define SFP_PINS_RST      4'h9
`define SFP_CLK_MHZ       40
`define SFP_PROG_US       30
`define SFP_PROG_CYC      (`SFP_PROG_US * `SFP_CLK_MHZ)
`define SFP_SEC_ERASE_MS  1000
`define SFP_CHIP_ERASE_MS 4000
`endif

// ==== verilog/sfp_pkg.sv ====
// sfp_pkg: state and command types plus shared decoders
// assumes sfp_regs.svh on the include path
`include "sfp_regs.svh"
package sfp_pkg;
  typedef enum logic [1:0] {T_OP, T_ADDR, T_DATA, T_SKIP} sfp_xfer_t;
  typedef enum logic [1:0] {C_IDLE, C_PROG, C_WAIT} sfp_cyc_t;
  typedef enum logic [3:0] {K_NONE, K_UNLOCK, K_LOCK, K_STAT_RD, K_STAT_WR,
                            K_READ, K_PROG, K_SEC, K_CHIP} sfp_cmd_t;

  function automatic sfp_cmd_t sfp_decode(input logic [7:0] op);
    case (op & `SFP_OP_MASK)
      `SFP_OP_UNLOCK:     return K_UNLOCK;
      `SFP_OP_LOCK:       return K_LOCK;
      `SFP_OP_STAT_RD:    return K_STAT_RD;
      `SFP_OP_STAT_WR:    return K_STAT_WR;
      `SFP_OP_READ:       return K_READ;
      `SFP_OP_PROG:       return K_PROG;
      `SFP_OP_SEC_ERASE:  return K_SEC;
      `SFP_OP_CHIP_ERASE: return K_CHIP;
      default:            return K_NONE;
    endcase
  endfunction : sfp_decode

  // one bit per sector, sector 3 at the top of the array
  function automatic logic [3:0] sfp_guard_mask(input logic [1:0] bg);
    unique case (bg)
      2'h0: return 4'h0;
      2'h1: return 4'h8;
      2'h2: return 4'hc;
      2'h3: return 4'hf;
    endcase
  endfunction : sfp_guard_mask
endpackage : sfp_pkg

// ==== verilog/sfp_buf2.sv ====
`timescale 1ns/1ps
// sfp_buf2: small valid/ready buffer in front of the array write port
// assumes both sides run on the same clock
module sfp_buf2
#(
  parameter int W     = 26,
  parameter int DEPTH = 2
)
(
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign o_in_ready  = cnt_r != FULL;
  assign o_out_valid = cnt_r != '0;
  assign o_out_data  = mem_r[rp_r];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem_r[wp_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop)
      begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sfp_buf2

// ==== bench/sfp_spi_host.sv ====
`timescale 1ns/1ps
// sfp_spi_host: mode 0 spi host model for the flash pins
// assumes a 40 MHz i_clk; one sck period is 8 of its cycles
module sfp_spi_host
(
  input  wire logic i_clk,
  input  wire logic i_so,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si
);
  logic [7:0] rx [$];
  logic       busy;

  initial
  begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_si   = 1'b0;
    busy   = 1'b0;
  end

  // released data line toggles so no stale level is mistaken for data
  always @(posedge i_clk)
    if (!busy)
      o_si <= ~o_si;

  task automatic bit_x(input logic d, output logic q);
    o_si <= d;
    repeat (4) @(posedge i_clk);
    o_sck <= 1'b1;
    repeat (4) @(posedge i_clk);
    q = i_so;
    o_sck <= 1'b0;
  endtask : bit_x

  task automatic frame(input logic [7:0] tx [$], input int nrd);
    logic [7:0] v;
    rx = {};
    busy = 1'b1;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    foreach (tx[k])
      for (int b = 7; b >= 0; b--)
        bit_x(tx[k][b], v[0]);
    repeat (nrd)
    begin
      for (int b = 7; b >= 0; b--)
        bit_x(~o_si, v[b]);
      rx.push_back(v);
    end
    repeat (4) @(posedge i_clk);
    o_cs_n <= 1'b1; // released in sck low time
    busy <= 1'b0;
    repeat (10) @(posedge i_clk);
  endtask : frame
endmodule : sfp_spi_host

// ==== bench/spi_flash_protect_program_erase_test.sv ====
`timescale 1ns/1ps
// bench top: drives sfp_core through the host model, models the array
// assumes sfp_spi_host is compiled before this file
module spi_flash_protect_program_erase_test;
  logic        clk, rst_n, wp_n, so, so_oe_n, cs_n, sck, si, so_line;
  logic [1:0]  cyc;
  logic        wr_valid, wr_ready, erase;
  logic [1:0]  cnt;
  logic [3:0]  mask;
  logic [7:0]  rd_data, wr_data;
  logic [17:0] rd_addr, wr_addr;
  logic [7:0]  mem [0:262143];
  logic [7:0]  q [$];
  logic [15:0] rows [6] = '{16'h0e02, 16'h0400, 16'h0602, 16'h0d02,
                            16'h0c00, 16'h0602};
  int          bad_count, total_checks;

  sfp_core #(.SEC_ERASE_CYC(50), .CHIP_ERASE_CYC(80)) i_dut
  (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_sck(sck),
    .i_si(si), .i_wp_n(wp_n), .o_so(so), .o_so_oe_n(so_oe_n),
    .o_mem_rd_addr(rd_addr), .i_mem_rd_data(rd_data),
    .o_mem_wr_valid(wr_valid), .i_mem_wr_ready(wr_ready),
    .o_mem_wr_addr(wr_addr), .o_mem_wr_data(wr_data),
    .o_mem_erase(erase), .o_mem_erase_mask(mask), .o_cyc_state(cyc)
  );

  // a floating output line shows the inverse of the stale bit
  assign so_line = so_oe_n ? ~so : so;

  sfp_spi_host i_host
  (
    .i_clk(clk), .i_so(so_line), .o_cs_n(cs_n), .o_sck(sck), .o_si(si)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // array: data one cycle after address, writes stall 3 cycles of 4
  always @(posedge clk)
  begin
    cnt      <= cnt + 2'h1;
    wr_ready <= (cnt == 2'h0);
    rd_data  <= mem[rd_addr];
    if (wr_valid && wr_ready)
      mem[wr_addr] <= wr_data;
    if (erase)
      for (int a = 0; a < 262144; a++)
        if (mask[a[17:16]])
          mem[a] <= 8'hff;
  end

  function automatic logic [7:0] ini(input int a);
    return a[7:0] ^ 8'h3c;
  endfunction : ini

  function automatic logic [7:0] dv(input int k);
    return k[8:1] ^ 8'ha5;
  endfunction : dv

  task automatic stop_test;
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk8

  task automatic st(input logic [7:0] exp);
    i_host.frame({8'h05}, 1);
    chk8(i_host.rx[0], exp);
  endtask : st

  task automatic rdchk(input logic [17:0] a, input logic [7:0] e [$]);
    i_host.frame({8'h03, 8'(a[17:16]), a[15:8], a[7:0]}, e.size());
    foreach (e[k])
      chk8(i_host.rx[k], e[k]);
  endtask : rdchk

  // unlock in a frame of its own first
  task automatic wcmd(input logic [7:0] tx [$]);
    i_host.frame({8'h06}, 0);
    i_host.frame(tx, 0);
  endtask : wcmd

  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      i_host.frame({8'h05}, 1);
      n++;
    end
    while (i_host.rx[0][0] !== 1'b0 && n < 300);
    if (i_host.rx[0][0] !== 1'b0)
    begin
      bad_count++;
      stop_test();
    end
  endtask : wait_idle

  initial
  begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    rd_data = 8'h00;
    wr_ready = 1'b0;
    cnt = 2'h0;
    bad_count = 0;
    total_checks = 0;
    for (int a = 0; a < 262144; a++)
      mem[a] = ini(a);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk8({7'h0, so_oe_n}, 8'h01);
    st(8'h00);
    i_host.frame({8'h02, 8'h00, 8'h00, 8'h00, 8'h77}, 0);
    rdchk(18'h0, {8'h3c});
    st(8'h00);
    foreach (rows[i])
    begin
      i_host.frame({rows[i][15:8]}, 0);
      st(rows[i][7:0]);
    end
    // sector erased before it is programmed
    wcmd({8'h52, 8'h01, 8'h23, 8'h45});
    wait_idle();
    rdchk(18'h0ffff, {8'hc3, 8'hff});
    q = {8'h02, 8'h01, 8'h00, 8'hfe};
    for (int k = 0; k < 258; k++)
      q.push_back(dv(k));
    wcmd(q);
    chk8({6'h0, cyc}, {6'h0, 2'(sfp_pkg::C_PROG)});
    st(8'hff);
    i_host.frame({8'h06}, 0);
    wait_idle();
    st(8'h00);
    rdchk(18'h100fd, {dv(255), dv(256), dv(257), 8'hff});
    wcmd({8'h01, 8'h84});
    wait_idle();
    st(8'h84);
    wp_n <= 1'b0;
    wcmd({8'h01, 8'h00});
    i_host.frame({8'h04}, 0);
    st(8'h84);
    wcmd({8'h52, 8'h03, 8'h00, 8'h00});
    i_host.frame({8'h04}, 0);
    rdchk(18'h30000, {8'h3c});
    wcmd({8'h62});
    wait_idle();
    rdchk(18'h3fffe, {8'hc2, 8'hc3, 8'hff});
    st(8'h84);
    wp_n <= 1'b1;
    wcmd({8'h01, 8'h00});
    wait_idle();
    st(8'h00);
    // reset in mid-run drops a set latch
    i_host.frame({8'h06}, 0);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk8({6'h0, cyc}, {6'h0, 2'(sfp_pkg::C_IDLE)});
    st(8'h00);
    stop_test();
  end
endmodule : spi_flash_protect_program_erase_test
